/* File: hw/port_read_data_select.sv */
// The register addresses and the Wishbone slave port were chosen for this implementation.
module port_read_data_select
   import port_rdsel_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   output logic             ack_o,
   output logic      [31:0] dat_o,
   input  wire logic [2:0]  mode_pin,
   input  wire port_vec_t   pin_in,
   input  wire int_src_s    int_src,
   output port_vec_t        pin_out,
   output port_vec_t        pin_oe_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   port_vec_t  pin_s1;
   port_vec_t  pin_s2;
   logic [2:0] mode_s1;
   logic [2:0] mode_s2;

   port_vec_t  latch;
   port_vec_t  dir;
   func_ctrl_s ctrl;
   logic [2:0] mode;
   boot_e      boot;

   port_vec_t  next_latch;
   port_vec_t  next_dir;
   func_ctrl_s next_ctrl;
   logic [2:0] next_mode;
   boot_e      next_boot;
   logic       next_ack;
   logic [31:0] next_dat;
   port_vec_t  next_pin_out;
   port_vec_t  next_pin_oe_n;

   port_vec_t  port_read;
   logic [2:0] region;
   logic [2:0] index;

   // Decoded request terms
   logic       take;
   logic       wr_en;
   logic       port_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Selection functions

   function automatic logic is_ext_mode(input logic [2:0] md);
      is_ext_mode = (md == MODE1) || (md == MODE2) || (md == MODE3) || (md == MODE4);
   endfunction

   function automatic logic read_bit(
      input int         p,
      input int         b,
      input logic [2:0] md,
      input func_ctrl_s c,
      input logic       pin,
      input logic       lat,
      input logic       ddr,
      input int_src_s   s
   );
      logic gen;
      logic ext;
      gen      = ddr ? lat : pin;
      ext      = is_ext_mode(md);
      read_bit = gen;
      case (p)
         0: begin
            case (b)
               0: read_bit = ddr ? s.sys_clock : pin;
               1: read_bit = ddr ? s.e_clock : pin;
               2: read_bit = (ext && c.bus_release_enable) ? lat : gen;
               3: read_bit = (ext && c.bus_release_enable) ? pin : gen;
               4: read_bit = (ext && c.wait_select_bit1) ? pin : gen;
               5: read_bit = c.ext_int0_enable ? pin : gen;
               6: begin
                  if (c.trigger_input_enable || c.ext_int1_enable) begin
                     read_bit = pin;
                  end
               end
               7: read_bit = c.timer_out_enable ? s.timer8_out : gen;
               default: read_bit = gen;
            endcase
         end
         1: read_bit = ext ? lat : gen;
         2: read_bit = ext ? 1'b1 : gen;
         3: read_bit = ext ? lat : gen;
         4: read_bit = ((md == MODE1) || (md == MODE3)) ? lat : gen;
         default: read_bit = gen;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Per-bit read and drive selection

   generate
      for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         for (genvar gb = 0; gb < PORT_W; gb++) begin : g_bit
            assign port_read[gp][gb] = read_bit(gp, gb, mode, ctrl, pin_s2[gp][gb],
                                                latch[gp][gb], dir[gp][gb], int_src);
            if (gp == 0 && gb == 0) begin : g_sysclk
               assign next_pin_out[gp][gb]  = dir[gp][gb] ? int_src.sys_clock : 1'b0;
               assign next_pin_oe_n[gp][gb] = ~dir[gp][gb];
            end else if (gp == 0 && gb == 1) begin : g_eclk
               assign next_pin_out[gp][gb]  = dir[gp][gb] ? int_src.e_clock : 1'b0;
               assign next_pin_oe_n[gp][gb] = ~dir[gp][gb];
            end else if (gp == 0 && gb == 7) begin : g_timer
               // Timer output drives the pin whatever the direction bit says
               assign next_pin_out[gp][gb]  = ctrl.timer_out_enable ? int_src.timer8_out
                                                                     : latch[gp][gb];
               assign next_pin_oe_n[gp][gb] = ~(dir[gp][gb] | ctrl.timer_out_enable);
            end else begin : g_plain
               assign next_pin_out[gp][gb]  = latch[gp][gb];
               assign next_pin_oe_n[gp][gb] = ~dir[gp][gb];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign region   = adr_i[REGION_LSB +: 3];
   assign index    = adr_i[INDEX_LSB +: 3];
   assign port_hit = (index < 3'(NUM_PORTS));
   // A held strobe is taken every second cycle; the pending ack blocks only the next take
   assign take     = cyc_i && stb_i && !ack_o;
   // Misaligned and lane-off writes change nothing
   assign wr_en    = take && we_i && sel_i[0] && (adr_i[1:0] == 2'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // Mode strap

   // Straps are caught once, the first edge after reset release
   always_comb begin
      next_mode = mode;
      next_boot = boot;
      case (boot)
         ST_STRAP: begin
            next_mode = mode_s2;
            next_boot = ST_RUN;
         end
         ST_RUN: begin
            next_boot = ST_RUN;
         end
         default: begin
            next_boot = ST_STRAP;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode <= MODE_RST;
         boot <= ST_STRAP;
      end else begin
         mode <= next_mode;
         boot <= next_boot;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Writable registers

   always_comb begin
      next_latch = latch;
      next_dir   = dir;
      next_ctrl  = ctrl;
      if (wr_en) begin
         case (region)
            REGION_LATCH: begin
               if (port_hit) begin
                  next_latch[index] = dat_i[7:0];
               end
            end
            REGION_DIR: begin
               if (port_hit) begin
                  next_dir[index] = dat_i[7:0];
               end
            end
            REGION_MISC: begin
               if (index == MISC_CTRL_IDX) begin
                  next_ctrl = func_ctrl_s'(dat_i[5:0]);
               end
            end
            default: begin
               next_ctrl = ctrl;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         latch <= {NUM_PORTS{LATCH_RST}};
         dir   <= {NUM_PORTS{DIR_RST}};
         ctrl  <= func_ctrl_s'(CTRL_RST);
      end else begin
         latch <= next_latch;
         dir   <= next_dir;
         ctrl  <= next_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus answer

   always_comb begin
      next_ack = take;
      next_dat = dat_o;
      if (take) begin
         // Refused addresses still answer, with zero data
         next_dat = 32'h0000_0000;
         if (adr_i[1:0] == 2'h0) begin
            case (region)
               REGION_LATCH: begin
                  if (port_hit) begin
                     next_dat[7:0] = latch[index];
                  end
               end
               REGION_DIR: begin
                  if (port_hit) begin
                     next_dat[7:0] = dir[index];
                  end
               end
               REGION_READ: begin
                  if (port_hit) begin
                     next_dat[7:0] = port_read[index];
                  end
               end
               REGION_MISC: begin
                  if (index == MISC_CTRL_IDX) begin
                     next_dat[5:0] = ctrl;
                  end else if (index == MISC_MODE_IDX) begin
                     next_dat[2:0] = mode;
                  end
               end
               default: begin
                  next_dat = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drive and synchronisers

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pin_out  <= '0;
         pin_oe_n <= '1;
      end else begin
         pin_out  <= next_pin_out;
         pin_oe_n <= next_pin_oe_n;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // No reset: the straps must settle while reset is still held
   always_ff @(posedge sys_clk) begin
      mode_s1 <= mode_pin;
      mode_s2 <= mode_s1;
   end

endmodule // port_read_data_select

/* File: hw/port_rdsel_pkg.sv */
package port_rdsel_pkg;

   localparam int NUM_PORTS = 5;
   localparam int PORT_W    = 8;

   // Register regions: address bits [7:5] pick the region, bits [4:2] the port
   localparam int          REGION_LSB    = 5;
   localparam int          INDEX_LSB     = 2;
   localparam logic [2:0]  REGION_LATCH  = 3'h0;
   localparam logic [2:0]  REGION_DIR    = 3'h1;
   localparam logic [2:0]  REGION_READ   = 3'h2;
   localparam logic [2:0]  REGION_MISC   = 3'h3;
   localparam logic [2:0]  MISC_CTRL_IDX = 3'h0;
   localparam logic [2:0]  MISC_MODE_IDX = 3'h1;

   // Operating modes
   localparam logic [2:0] MODE1 = 3'h1;
   localparam logic [2:0] MODE2 = 3'h2;
   localparam logic [2:0] MODE3 = 3'h3;
   localparam logic [2:0] MODE4 = 3'h4;
   localparam logic [2:0] MODE7 = 3'h7;

   // Values after reset
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] DIR_RST   = 8'h00;
   localparam logic [5:0] CTRL_RST  = 6'h00;
   localparam logic [2:0] MODE_RST  = MODE7;

   typedef enum logic [1:0] {
      ST_STRAP = 2'b01,
      ST_RUN   = 2'b10
   } boot_e;

   // Control register, bit 0 is bus_release_enable
   typedef struct packed {
      logic timer_out_enable;
      logic trigger_input_enable;
      logic ext_int1_enable;
      logic ext_int0_enable;
      logic wait_select_bit1;
      logic bus_release_enable;
   } func_ctrl_s;

   // Internal sources that can replace a pin on read
   typedef struct packed {
      logic sys_clock;
      logic e_clock;
      logic timer8_out;
   } int_src_s;

   typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_vec_t;

endpackage

/* File: bench/pin_model.sv */
module pin_model
   import port_rdsel_pkg::*;
(
   input  wire port_vec_t pin_out,
   input  wire port_vec_t pin_oe_n,
   input  wire port_vec_t ext_level,
   output port_vec_t      pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins take the far side level, never the last driven one
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // pin_model

/* File: bench/port_rdsel_props.sv */
module port_rdsel_props
   import port_rdsel_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [7:0]  adr_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire int_src_s    int_src,
   input wire port_vec_t   pin_out,
   input wire port_vec_t   pin_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
   a_ack_cause: assert property (ack_o |-> $past(stb_i)) else $error("ack unasked");
   a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits");
   a_misalign_zero: assert property (ack_o && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0)
      else $error("misaligned data");
   a_unmapped_zero: assert property (ack_o && adr_i[7:5] > 3'h3 |-> dat_o == 32'h0)
      else $error("unmapped data");
   a_sysclk_drive:
      assert property (!pin_oe_n[0][0] |-> pin_out[0][0] == $past(int_src.sys_clock))
      else $error("bit0 drive");
   a_eclk_drive:
      assert property (!pin_oe_n[0][1] |-> pin_out[0][1] == $past(int_src.e_clock))
      else $error("bit1 drive");
endmodule // port_rdsel_props
bind port_read_data_select port_rdsel_props chk_u (.sys_clk(sys_clk), .rstn(rstn),
   .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i), .ack_o(ack_o), .dat_o(dat_o),
   .int_src(int_src), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

/* File: bench/tb_top.sv */
module tb_top;
   import port_rdsel_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, rstn = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic [3:0]  sel_i = 4'h0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, q, r, x;
   logic [2:0]  mode_pin = MODE7;
   logic [5:0]  c;
   int_src_s    int_src = 3'h0;
   port_vec_t   pin_in, pin_out, pin_oe_n, lat, dir, ext_level = '0;
   int          seed = 98215, bad_count = 0, n_compared = 0;
   logic [2:0]  modes [5] = '{MODE1, MODE2, MODE3, MODE4, MODE7};
   logic [7:0]  bad_adr [4] = '{8'h80, 8'h41, 8'h14, 8'h6c};
   always #25 sys_clk = ~sys_clk;
   port_read_data_select dut_u (.sys_clk(sys_clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .dat_o(dat_o),
      .mode_pin(mode_pin), .pin_in(pin_in), .int_src(int_src), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n));
   pin_model far_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
      .pin_in(pin_in));
   ////////////////////////////////////////
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, d, input logic s);
      int n;
      n = 0;
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, 24'h0, d, 3'h0, s};
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      {cyc_i, stb_i} <= 2'h0;
      @(posedge sys_clk);
      if (n < 20) return;
      chk(32'(n), 32'h0);
      wrap_up();
   endtask
   // l is the latch now, k the latch value that the synced pins still show
   function automatic logic [7:0] exp_rd(int p, logic [2:0] m, logic [7:0] l, k, d, e,
                                         logic [5:0] f, int_src_s s);
      logic [7:0] pin, ovr, rd;
      logic       b;
      b = m inside {MODE1, MODE2, MODE3, MODE4};
      pin = (d & k) | (~d & e);
      if (p == 0) pin = {f[5] ? s.timer8_out : pin[7], pin[6:2],
                         d[1] ? s.e_clock : e[1], d[0] ? s.sys_clock : e[0]};
      ovr = (p == 0) ? {f[5], f[4] | f[3], f[2], b & f[1], b & f[0], 3'h3} : 8'h0;
      rd = (ovr & pin) | (~ovr & ((d & l) | (~d & pin)));
      if (p == 0 && b && f[0]) rd[2] = l[2];
      if ((p == 1 || p == 3) && b) rd = l;
      if (p == 2 && b) rd = 8'hff;
      if (p == 4 && (m == MODE1 || m == MODE3)) rd = l;
      return rd;
   endfunction
   initial begin
      for (int i = 0; i < 5; i++) begin
         rstn <= 1'b0;
         mode_pin <= modes[i];
         repeat (2) @(posedge sys_clk);
         rstn <= 1'b1;
         repeat (3) @(posedge sys_clk);
         chk({24'h0, pin_oe_n[1]}, 32'hff);
         wb(1'b0, 8'h04, 8'h00, 1'b1);
         chk(q, {24'h0, LATCH_RST});
         wb(1'b0, 8'h64, 8'h00, 1'b1);
         chk(q, {29'h0, modes[i]});
         r = $random(seed);
         // Corners: all functions on in mode 1, all off in mode 7
         c = (i == 0) ? 6'h3f : (i == 4) ? 6'h00 : r[5:0];
         int_src <= r[8:6];
         wb(1'b1, 8'h60, {2'h0, c}, 1'b1);
         for (int p = 0; p < 5; p++) begin
            r = $random(seed);
            lat[p] = r[7:0];
            dir[p] = r[15:8];
            ext_level[p] <= r[23:16];
            wb(1'b1, 8'(4 * p), lat[p], 1'b1);
            wb(1'b1, 8'(32 + 4 * p), dir[p], 1'b1);
         end
         // Pin levels reach the read path two edges late
         repeat (4) @(posedge sys_clk);
         for (int p = 0; p < 5; p++) begin
            wb(1'b0, 8'(64 + 4 * p), 8'h00, 1'b1);
            x = {24'h0, exp_rd(p, modes[i], lat[p], lat[p], dir[p], ext_level[p], c,
                               int_src)};
            if (p == 0) chk(q, x);
            else chk(q, x);
            x = {16'h0, lat[p] & dir[p], ~dir[p]};
            if (p > 0) chk({16'h0, pin_out[p] & dir[p], pin_oe_n[p]}, x);
         end
         // Fresh latch against stale pins: only here do latch and pin reads differ
         for (int p = 0; p < 5; p++) begin
            wb(1'b1, 8'(4 * p), ~lat[p], 1'b1);
            wb(1'b0, 8'(64 + 4 * p), 8'h00, 1'b1);
            x = {24'h0, exp_rd(p, modes[i], ~lat[p], lat[p], dir[p], ext_level[p], c,
                               int_src)};
            chk(q, x);
         end
         $display("mode %0d test done", modes[i]);
      end
      wb(1'b1, 8'h00, 8'h5a, 1'b1);
      wb(1'b1, 8'h00, 8'ha5, 1'b0);
      wb(1'b1, 8'h64, 8'h02, 1'b1);
      wb(1'b0, 8'h00, 8'h00, 1'b1);
      chk(q, 32'h5a);
      wb(1'b0, 8'h64, 8'h00, 1'b1);
      chk(q, {29'h0, MODE7});
      foreach (bad_adr[k]) begin
         wb(1'b0, bad_adr[k], 8'h00, 1'b1);
         chk(q, 32'h0);
      end
      $display("refusal test done");
      wrap_up();
   end
endmodule // tb_top
